// ---- verilog/data_space_address_generation.sv ----
// data-space address generation: page registers, move operand modes, dsp prefetch pointers
// assumes a decoded request per cycle from the execution unit; answers one cycle later
`timescale 1ns/1ns

// Notes on behaviour
// - a 10-bit read page and a 9-bit write page register extend data reach
// - read with address bit 15 set, page bit 9 clear: page 8:0 above address 14:0
// - write with address bit 15 set: write page 8:0 above address 14:0
// - both page registers are readable and writable as control registers
// - move and accumulator operations also offer register indexed addressing
// - direct, indirect, post, pre, indexed, literal offset, 8 and 16 bit literals
// - source and destination modes may differ; one 4-bit offset field shared
// - dsp operand pointers come only from the four prefetch pointers
// - first two pointers read x space, last two read y space
// - indexed dsp addressing only on the second x and second y pointer
// - dsp modes: indirect, indexed, post-modify by 2, 4 or 6
module data_space_address_generation #(
  parameter int unsigned wreg_n = agu_pkg::wreg_count
) (
  input wire logic clk,
  input wire logic reset,
  input wire agu_pkg::page_wr_s page_wr,
  input wire agu_pkg::move_req_s move_req,
  input wire agu_pkg::dsp_req_s dsp_req,
  input wire logic [3:0] wreg_wr_sel,
  input wire logic wreg_wr_en,
  input wire logic [15:0] wreg_wr_data,
  output logic [9:0] read_page_q,
  output logic [8:0] write_page_q,
  output agu_pkg::mem_req_s x_rd_q,
  output agu_pkg::mem_req_s x_wr_q,
  output agu_pkg::mem_req_s y_rd_q,
  output logic [15:0] operand_literal_q,
  output logic operand_literal_valid_q,
  output logic dsp_illegal_q
);

  // the register select fields are 4 bits wide, so the pointer file must hold exactly 16 words
  if (wreg_n != 16) begin : g_bad_wreg_n
    $error("wreg_n must be 16 for a 4-bit register field");
  end

  logic [15:0] wreg_q [wreg_n];
  logic [15:0] wreg_d [wreg_n];
  logic [9:0] read_page_d;
  logic [8:0] write_page_d;
  agu_pkg::mem_req_s x_rd_d, x_wr_d, y_rd_d;
  logic [15:0] operand_literal_d;
  logic operand_literal_valid_d;
  logic dsp_illegal_d;
  logic [15:0] src_ea, dst_ea, x_ea, y_ea;
  logic src_mem, dst_mem;
  logic [23:0] src_ext, dst_ext, x_ext, y_ext;
  logic src_psv, x_psv, y_psv;
  logic dsp_legal;

  // effective address for a move operand mode, indexed uses the shared offset field
  function automatic logic [15:0] move_ea(input agu_pkg::move_opd_s o, input logic [15:0] base,
                                          input logic [15:0] offs);
    case (o.mode)
      agu_pkg::mode_pre_mod: move_ea = base + o.step;
      agu_pkg::mode_indexed: move_ea = base + offs;
      agu_pkg::mode_lit_offset: move_ea = base + o.step;
      default: move_ea = base;
    endcase
  endfunction

  // pointer update for a move operand mode
  function automatic logic [15:0] move_upd(input agu_pkg::move_opd_s o, input logic [15:0] base);
    case (o.mode)
      agu_pkg::mode_post_mod: move_upd = base + o.step;
      agu_pkg::mode_pre_mod: move_upd = base + o.step;
      default: move_upd = base;
    endcase
  endfunction

  // whether the mode touches data memory
  function automatic logic is_mem(input agu_pkg::move_mode_e m);
    is_mem = m inside {agu_pkg::mode_indirect, agu_pkg::mode_post_mod, agu_pkg::mode_pre_mod,
                       agu_pkg::mode_indexed, agu_pkg::mode_lit_offset};
  endfunction

  // dsp post-modify amount
  function automatic logic [15:0] dsp_step(input agu_pkg::dsp_mode_e m);
    case (m)
      agu_pkg::dsp_post2: dsp_step = 16'h0002;
      agu_pkg::dsp_post4: dsp_step = 16'h0004;
      agu_pkg::dsp_post6: dsp_step = 16'h0006;
      default: dsp_step = 16'h0000;
    endcase
  endfunction

  // operand effective addresses
  always_comb begin
    src_ea = move_ea(move_req.src, wreg_q[move_req.src.reg_sel], wreg_q[move_req.offset_register_field]);
    dst_ea = move_ea(move_req.dst, wreg_q[move_req.dst.reg_sel], wreg_q[move_req.offset_register_field]);
    src_mem = is_mem(move_req.src.mode);
    dst_mem = is_mem(move_req.dst.mode);
    x_ea = wreg_q[dsp_req.x_reg];
    y_ea = wreg_q[dsp_req.y_reg];
    if (dsp_req.x_mode == agu_pkg::dsp_indexed)
      x_ea = wreg_q[dsp_req.x_reg] + wreg_q[dsp_req.offset_register_field];
    if (dsp_req.y_mode == agu_pkg::dsp_indexed)
      y_ea = wreg_q[dsp_req.y_reg] + wreg_q[dsp_req.offset_register_field];
  end

  // read page applies to source reads, write page to destination writes
  ext_addr_form u_src (
    .effective_address(src_ea),
    .page(read_page_q),
    .is_read(1'b1),
    .ext_addr(src_ext),
    .program_space_visibility(src_psv)
  );

  ext_addr_form u_dst (
    .effective_address(dst_ea),
    .page({1'b0, write_page_q}),
    .is_read(1'b0),
    .ext_addr(dst_ext),
    .program_space_visibility()
  );

  ext_addr_form u_x (
    .effective_address(x_ea),
    .page(read_page_q),
    .is_read(1'b1),
    .ext_addr(x_ext),
    .program_space_visibility(x_psv)
  );

  ext_addr_form u_y (
    .effective_address(y_ea),
    .page(read_page_q),
    .is_read(1'b1),
    .ext_addr(y_ext),
    .program_space_visibility(y_psv)
  );

  dsp_pointer_check u_chk (
    .x_reg(dsp_req.x_reg),
    .x_mode(dsp_req.x_mode),
    .y_reg(dsp_req.y_reg),
    .y_mode(dsp_req.y_mode),
    .legal(dsp_legal)
  );

  // next state of page registers, pointers and memory port requests
  always_comb begin
    read_page_d = read_page_q;
    write_page_d = write_page_q;
    wreg_d = wreg_q;
    x_rd_d = '0;
    x_wr_d = '0;
    y_rd_d = '0;
    operand_literal_d = operand_literal_q;
    operand_literal_valid_d = 1'b0;
    dsp_illegal_d = 1'b0;
    if (page_wr.wr_read_page)
      read_page_d = page_wr.wdata[agu_pkg::read_page_w-1:0];
    if (page_wr.wr_write_page)
      write_page_d = page_wr.wdata[agu_pkg::write_page_w-1:0];
    if (wreg_wr_en)
      wreg_d[wreg_wr_sel] = wreg_wr_data;
    if (move_req.valid) begin
      // each side keeps its own mode; direct, 8-bit and 16-bit literal modes touch no memory
      if (src_mem) begin
        x_rd_d.valid = 1'b1;
        x_rd_d.addr = src_ext;
        x_rd_d.program_space_visibility = src_psv;
      end
      if (move_req.src.mode == agu_pkg::mode_lit8) begin
        operand_literal_d = {8'h00, move_req.src.literal[7:0]};
        operand_literal_valid_d = 1'b1;
      end
      if (move_req.src.mode == agu_pkg::mode_lit16 || move_req.src.mode == agu_pkg::mode_direct) begin
        operand_literal_d = (move_req.src.mode == agu_pkg::mode_direct) ?
                            wreg_q[move_req.src.reg_sel] : move_req.src.literal;
        operand_literal_valid_d = 1'b1;
      end
      if (dst_mem) begin
        x_wr_d.valid = 1'b1;
        x_wr_d.write = 1'b1;
        x_wr_d.addr = dst_ext;
      end
      wreg_d[move_req.src.reg_sel] = move_upd(move_req.src, wreg_q[move_req.src.reg_sel]);
      if (move_req.dst.reg_sel != move_req.src.reg_sel || move_req.dst.mode inside
          {agu_pkg::mode_post_mod, agu_pkg::mode_pre_mod})
        wreg_d[move_req.dst.reg_sel] = move_upd(move_req.dst, wreg_q[move_req.dst.reg_sel]);
    end else if (dsp_req.valid) begin
      if (!dsp_legal) begin
        dsp_illegal_d = 1'b1;
      end else begin
        // x pointers feed the x generator, y pointers the y generator
        if (dsp_req.x_mode != agu_pkg::dsp_none) begin
          x_rd_d.valid = 1'b1;
          x_rd_d.addr = x_ext;
          x_rd_d.program_space_visibility = x_psv;
          wreg_d[dsp_req.x_reg] = wreg_q[dsp_req.x_reg] + dsp_step(dsp_req.x_mode);
        end
        if (dsp_req.y_mode != agu_pkg::dsp_none) begin
          y_rd_d.valid = 1'b1;
          y_rd_d.addr = y_ext;
          y_rd_d.program_space_visibility = y_psv;
          wreg_d[dsp_req.y_reg] = wreg_q[dsp_req.y_reg] + dsp_step(dsp_req.y_mode);
        end
      end
    end
  end

  // registers
  always_ff @(posedge clk) begin
    if (reset) begin
      read_page_q <= agu_pkg::read_page_reset;
      write_page_q <= agu_pkg::write_page_reset;
      for (int i = 0; i < wreg_n; i++) wreg_q[i] <= 16'h0000;
      x_rd_q <= '0;
      x_wr_q <= '0;
      y_rd_q <= '0;
      operand_literal_q <= 16'h0000;
      operand_literal_valid_q <= 1'b0;
      dsp_illegal_q <= 1'b0;
    end else begin
      read_page_q <= read_page_d;
      write_page_q <= write_page_d;
      wreg_q <= wreg_d;
      x_rd_q <= x_rd_d;
      x_wr_q <= x_wr_d;
      y_rd_q <= y_rd_d;
      operand_literal_q <= operand_literal_d;
      operand_literal_valid_q <= operand_literal_valid_d;
      dsp_illegal_q <= dsp_illegal_d;
    end
  end

endmodule // data_space_address_generation

// ---- verilog/agu_pkg.sv ----
// package for the data-space address generation block: widths, page layout, mode codes, carrier structs
// assumes the core's execution unit supplies decoded operand requests on the same clock
package agu_pkg;

  localparam int unsigned data_w = 16;
  localparam int unsigned ext_w = 24;
  localparam int unsigned read_page_w = 10; // read page register width
  localparam int unsigned write_page_w = 9; // write page register width
  localparam int unsigned page_sel_w = 9; // page bits placed above the low address
  localparam int unsigned low_w = 15; // effective address bits 14:0
  localparam int unsigned page_top_bit = 15; // effective address bit that selects paging
  localparam int unsigned psv_bit = 9; // read page bit that selects program-space visibility
  localparam int unsigned offset_field_w = 4; // shared offset register field
  localparam int unsigned wreg_count = 16;
  localparam logic [9:0] read_page_reset = 10'h001;
  localparam logic [8:0] write_page_reset = 9'h001;

  // working register numbers of the four prefetch pointers
  localparam logic [3:0] x_prefetch_pointer_first = 4'h8;
  localparam logic [3:0] x_prefetch_pointer_second = 4'h9;
  localparam logic [3:0] y_prefetch_pointer_first = 4'ha;
  localparam logic [3:0] y_prefetch_pointer_second = 4'hb;

  // operand modes of move and accumulator instructions
  typedef enum logic [7:0] {
    mode_direct = 8'h01,
    mode_indirect = 8'h02,
    mode_post_mod = 8'h04,
    mode_pre_mod = 8'h08,
    mode_indexed = 8'h10,
    mode_lit_offset = 8'h20,
    mode_lit8 = 8'h40,
    mode_lit16 = 8'h80
  } move_mode_e;

  // operand modes of dual-operand dsp instructions
  typedef enum logic [2:0] {
    dsp_none = 3'h0,
    dsp_indirect = 3'h1,
    dsp_post2 = 3'h2,
    dsp_post4 = 3'h3,
    dsp_post6 = 3'h4,
    dsp_indexed = 3'h5
  } dsp_mode_e;

  // one operand of a move instruction
  typedef struct packed {
    move_mode_e mode;
    logic [3:0] reg_sel;
    logic signed [15:0] step; // pre or post modifier, literal offset
    logic [15:0] literal;
  } move_opd_s;

  // a whole move or accumulator request
  typedef struct packed {
    logic valid;
    move_opd_s src;
    move_opd_s dst;
    logic [3:0] offset_register_field;
  } move_req_s;

  // a dual-operand dsp request
  typedef struct packed {
    logic valid;
    logic [3:0] x_reg;
    dsp_mode_e x_mode;
    logic [3:0] y_reg;
    dsp_mode_e y_mode;
    logic [3:0] offset_register_field;
  } dsp_req_s;

  // one memory port request
  typedef struct packed {
    logic valid;
    logic write;
    logic program_space_visibility;
    logic [23:0] addr;
  } mem_req_s;

  // page register access from the special-function register area
  typedef struct packed {
    logic wr_read_page;
    logic wr_write_page;
    logic [15:0] wdata;
  } page_wr_s;

endpackage

// ---- verilog/ext_addr_form.sv ----
// forms an extended 24-bit address from an effective address and a page
// assumes purely combinational use inside the core's clock domain
`timescale 1ns/1ns
module ext_addr_form (
  input wire logic [15:0] effective_address,
  input wire logic [9:0] page,
  input wire logic is_read,
  output logic [23:0] ext_addr,
  output logic program_space_visibility
);

  // paging applies only with the top effective address bit set
  always_comb begin
    ext_addr = {8'h00, effective_address};
    program_space_visibility = 1'b0;
    if (effective_address[agu_pkg::page_top_bit]) begin
      ext_addr = {page[agu_pkg::page_sel_w-1:0], effective_address[agu_pkg::low_w-1:0]};
      program_space_visibility = is_read & page[agu_pkg::psv_bit];
    end
  end

endmodule // ext_addr_form

// ---- verilog/dsp_pointer_check.sv ----
// checks dual-operand dsp pointers against the pointer sets of the x and y generators
// assumes register numbers from the decoder on the same clock
`timescale 1ns/1ns
module dsp_pointer_check (
  input wire logic [3:0] x_reg,
  input wire agu_pkg::dsp_mode_e x_mode,
  input wire logic [3:0] y_reg,
  input wire agu_pkg::dsp_mode_e y_mode,
  output logic legal
);

  // pointer set, space routing and indexed restriction
  always_comb begin
    legal = 1'b1;
    if (x_mode != agu_pkg::dsp_none) begin
      if (x_reg != agu_pkg::x_prefetch_pointer_first && x_reg != agu_pkg::x_prefetch_pointer_second)
        legal = 1'b0;
      if (x_mode == agu_pkg::dsp_indexed && x_reg != agu_pkg::x_prefetch_pointer_second)
        legal = 1'b0;
    end
    if (y_mode != agu_pkg::dsp_none) begin
      if (y_reg != agu_pkg::y_prefetch_pointer_first && y_reg != agu_pkg::y_prefetch_pointer_second)
        legal = 1'b0;
      if (y_mode == agu_pkg::dsp_indexed && y_reg != agu_pkg::y_prefetch_pointer_second)
        legal = 1'b0;
    end
  end

endmodule // dsp_pointer_check

// ---- bench/agu_monitor.sv ----
// checker for the data-space address generation block, watching the top ports only
// assumes one core clock and the synchronous active-high reset of the design
`timescale 1ns/1ns
module agu_monitor (
  input wire logic clk,
  input wire logic reset,
  input wire agu_pkg::page_wr_s page_wr,
  input wire agu_pkg::move_req_s move_req,
  input wire agu_pkg::dsp_req_s dsp_req,
  input wire logic [9:0] read_page_q,
  input wire logic [8:0] write_page_q,
  input wire agu_pkg::mem_req_s x_rd_q,
  input wire agu_pkg::mem_req_s x_wr_q,
  input wire agu_pkg::mem_req_s y_rd_q,
  input wire logic [15:0] operand_literal_q,
  input wire logic operand_literal_valid_q,
  input wire logic dsp_illegal_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  logic dsp_take;
  logic dsp_bad;
  // a dsp request that is taken, and whether its pointers are forbidden
  assign dsp_take = dsp_req.valid && !move_req.valid && dsp_req.x_mode != agu_pkg::dsp_none
    && dsp_req.y_mode != agu_pkg::dsp_none;
  assign dsp_bad = !(dsp_req.x_reg inside {agu_pkg::x_prefetch_pointer_first, agu_pkg::x_prefetch_pointer_second})
    || !(dsp_req.y_reg inside {agu_pkg::y_prefetch_pointer_first, agu_pkg::y_prefetch_pointer_second})
    || (dsp_req.x_mode == agu_pkg::dsp_indexed && dsp_req.x_reg == agu_pkg::x_prefetch_pointer_first)
    || (dsp_req.y_mode == agu_pkg::dsp_indexed && dsp_req.y_reg == agu_pkg::y_prefetch_pointer_first);
  rd_page_load_a: assert property (page_wr.wr_read_page |=> read_page_q == $past(page_wr.wdata[9:0]))
    else $error("read page not loaded");
  wr_page_load_a: assert property (page_wr.wr_write_page |=> write_page_q == $past(page_wr.wdata[8:0]))
    else $error("write page not loaded");
  page_hold_a: assert property (!page_wr.wr_read_page && !page_wr.wr_write_page |=>
    $stable(read_page_q) && $stable(write_page_q)) else $error("page changed without a write");
  reset_value_a: assert property ($fell(reset) |-> read_page_q == agu_pkg::read_page_reset
    && write_page_q == agu_pkg::write_page_reset && !x_rd_q.valid) else $error("bad value after reset");
  rd_paged_a: assert property (x_rd_q.valid && !x_rd_q.program_space_visibility && x_rd_q.addr[23:16] != 0
    |-> x_rd_q.addr[23:15] == $past(read_page_q[8:0])) else $error("read page not above address");
  wr_paged_a: assert property (x_wr_q.valid && x_wr_q.addr[23:16] != 0
    |-> x_wr_q.addr[23:15] == $past(write_page_q)) else $error("write page not above address");
  wr_kind_a: assert property (x_wr_q.valid |-> x_wr_q.write && !x_wr_q.program_space_visibility)
    else $error("write port request malformed");
  dsp_refuse_a: assert property (dsp_take && dsp_bad |=> dsp_illegal_q && !x_rd_q.valid && !y_rd_q.valid)
    else $error("forbidden pointer not refused");
  dsp_route_a: assert property (dsp_take && !dsp_bad |=> !dsp_illegal_q && x_rd_q.valid && y_rd_q.valid)
    else $error("dsp reads not on both ports");
  lit16_a: assert property (move_req.valid && move_req.src.mode == agu_pkg::mode_lit16 |=>
    operand_literal_valid_q && operand_literal_q == $past(move_req.src.literal)) else $error("literal lost");
  // main scenarios reached
  psv_read_c: cover property (x_rd_q.valid && x_rd_q.program_space_visibility);
  dsp_bad_c: cover property (dsp_illegal_q);
  paged_write_c: cover property (x_wr_q.valid && x_wr_q.addr[23:16] != 0);
endmodule // agu_monitor

// ---- bench/mem_model.sv ----
// data memory stand-in on the x and y ports: counts every request pulse
// assumes requests are one-cycle pulses on the core clock
`timescale 1ns/1ns
module mem_model (
  input wire logic clk,
  input wire logic reset,
  input wire agu_pkg::mem_req_s x_rd,
  input wire agu_pkg::mem_req_s x_wr,
  input wire agu_pkg::mem_req_s y_rd,
  output logic [15:0] n_req
);
  // every port is always ready, so each pulse is one access
  always_ff @(posedge clk) begin
    if (reset) begin
      n_req <= '0;
    end else begin
      n_req <= n_req + 16'(x_rd.valid) + 16'(x_wr.valid) + 16'(y_rd.valid);
    end
  end
endmodule // mem_model

// ---- bench/tb_top.sv ----
// testbench: random move and dsp requests with page writes, checked against bench models
// assumes agu_pkg, the design, the checker and the memory stand-in are compiled first
`timescale 1ns/1ns
module tb_top;
  logic clk = 0;
  logic reset = 1;
  agu_pkg::page_wr_s page_wr = '0;
  agu_pkg::move_req_s move_req = '0;
  agu_pkg::dsp_req_s dsp_req = '0;
  logic [3:0] wreg_wr_sel = '0;
  logic wreg_wr_en = 0;
  logic [15:0] wreg_wr_data = '0;
  logic [9:0] read_page_q;
  logic [8:0] write_page_q;
  agu_pkg::mem_req_s x_rd_q, x_wr_q, y_rd_q;
  logic [15:0] operand_literal_q, n_mem, lit, xe, ye;
  logic operand_literal_valid_q, dsp_illegal_q, bad;
  logic [15:0] r [16];
  logic [9:0] rp;
  logic [8:0] wp;
  logic [3:0] xr, yr;
  agu_pkg::move_mode_e sm, dm;
  agu_pkg::dsp_mode_e xm, ym;
  int n_fail = 0;
  int compares = 0;
  int n_exp = 0;
  int k;
  always #2 clk = ~clk;
  data_space_address_generation uut (.clk, .reset, .page_wr, .move_req, .dsp_req, .wreg_wr_sel, .wreg_wr_en,
    .wreg_wr_data, .read_page_q, .write_page_q, .x_rd_q, .x_wr_q, .y_rd_q, .operand_literal_q,
    .operand_literal_valid_q, .dsp_illegal_q);
  mem_model mem (.clk, .reset, .x_rd(x_rd_q), .x_wr(x_wr_q), .y_rd(y_rd_q), .n_req(n_mem));
  // bench models of address forming and pointer update
  function automatic logic [24:0] ext_f(logic [15:0] ea, logic [9:0] pg, logic rd);
    return {rd & ea[15] & pg[9], ea[15] ? {pg[8:0], ea[14:0]} : {8'h00, ea}};
  endfunction
  function automatic logic [15:0] ea_f(agu_pkg::move_mode_e m, logic [15:0] p, logic [15:0] s, logic [15:0] o);
    if (m inside {agu_pkg::mode_pre_mod, agu_pkg::mode_lit_offset}) return p + s;
    if (m == agu_pkg::mode_indexed) return p + o;
    return p;
  endfunction
  function automatic logic [15:0] upd_f(agu_pkg::move_mode_e m, logic [15:0] p, logic [15:0] s);
    return (m inside {agu_pkg::mode_pre_mod, agu_pkg::mode_post_mod}) ? p + s : p;
  endfunction
  // bus helpers and comparisons
  task automatic go;
    @(posedge clk);
    #1;
  endtask
  task automatic wreg(logic [3:0] s, logic [15:0] d);
    wreg_wr_en = 1;
    wreg_wr_sel = s;
    wreg_wr_data = d;
    r[s] = d;
    go;
  endtask
  task automatic chk(logic [31:0] g, logic [31:0] e);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk_req(agu_pkg::mem_req_s g, logic [24:0] e);
    n_exp++;
    chk(32'(g.valid), 1);
    chk(32'(g.program_space_visibility), 32'(e[24]));
    if (!e[24]) chk(32'(g.addr), 32'(e[23:0]));
  endtask
  task automatic complete_run;
    if (n_fail == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    #20000;
    n_fail++;
    complete_run;
  end
  // main sequence
  initial begin
    void'($urandom(47));
    repeat (16) go;
    reset = 0;
    go;
    chk(32'(read_page_q), 32'h001);
    chk(32'(write_page_q), 32'h001);
    for (int i = 0; i < 48; i++) begin
      k = (i < 8) ? i : $urandom_range(0, 7);
      sm = agu_pkg::move_mode_e'(8'h01 << k);
      dm = agu_pkg::move_mode_e'(8'h01 << $urandom_range(1, 5));
      page_wr = {2'b11, 16'($urandom)};
      rp = page_wr.wdata[9:0];
      wp = page_wr.wdata[8:0];
      wreg(4'h1, 16'($urandom));
      page_wr = '0;
      wreg(4'h4, 16'($urandom));
      wreg(4'hc, 16'($urandom));
      wreg_wr_en = 0;
      chk(32'(read_page_q), 32'(rp));
      chk(32'(write_page_q), 32'(wp));
      lit = 16'($urandom);
      move_req = {1'b1, sm, 4'h1, 16'($urandom_range(0, 15) * 2), lit, dm, 4'h4, 16'($urandom), 16'h0, 4'hc};
      dsp_req = {1'b1, 4'h0, agu_pkg::dsp_indirect, 4'h0, agu_pkg::dsp_indirect, 4'h0};
      go;
      chk(32'(dsp_illegal_q), 0);
      chk(32'(y_rd_q.valid), 0);
      if (k == 0 || k > 5) begin
        chk(32'(x_rd_q.valid), 0);
        chk(32'(operand_literal_valid_q), 1);
        chk(32'(operand_literal_q), k == 0 ? 32'(r[1]) : k == 6 ? 32'(lit[7:0]) : 32'(lit));
      end else begin
        chk_req(x_rd_q, ext_f(ea_f(sm, r[1], move_req.src.step, r[12]), rp, 1));
      end
      chk_req(x_wr_q, ext_f(ea_f(dm, r[4], move_req.dst.step, r[12]), {1'b0, wp}, 0));
      r[1] = upd_f(sm, r[1], move_req.src.step);
      r[4] = upd_f(dm, r[4], move_req.dst.step);
      move_req.src.mode = agu_pkg::mode_indirect;
      move_req.dst.mode = agu_pkg::mode_indirect;
      dsp_req.valid = 0;
      go;
      chk_req(x_rd_q, ext_f(r[1], rp, 1));
      chk_req(x_wr_q, ext_f(r[4], {1'b0, wp}, 0));
      move_req.valid = 0;
    end
    for (int i = 0; i < 48; i++) begin
      xr = 4'(7 + $urandom_range(0, 3));
      yr = 4'(9 + $urandom_range(0, 3));
      xm = agu_pkg::dsp_mode_e'(3'($urandom_range(1, 5)));
      ym = agu_pkg::dsp_mode_e'(3'($urandom_range(1, 5)));
      for (int j = 8; j < 12; j++) wreg(4'(j), 16'($urandom_range(0, 16'h37ff) * 2));
      wreg(4'hc, 16'($urandom_range(0, 255) * 2));
      wreg_wr_en = 0;
      dsp_req = {1'b1, xr, xm, yr, ym, 4'hc};
      go;
      bad = !(xr inside {4'h8, 4'h9}) || !(yr inside {4'ha, 4'hb}) || (xm == agu_pkg::dsp_indexed && xr == 4'h8)
        || (ym == agu_pkg::dsp_indexed && yr == 4'ha);
      chk(32'(dsp_illegal_q), 32'(bad));
      if (bad) begin
        chk(32'(x_rd_q.valid | y_rd_q.valid), 0);
        xr = 4'h8;
        yr = 4'ha;
      end else begin
        xe = (xm == agu_pkg::dsp_indexed) ? r[xr] + r[12] : r[xr];
        ye = (ym == agu_pkg::dsp_indexed) ? r[yr] + r[12] : r[yr];
        chk_req(x_rd_q, ext_f(xe, 10'h000, 1));
        chk_req(y_rd_q, ext_f(ye, 10'h000, 1));
        if (xm inside {[agu_pkg::dsp_post2 : agu_pkg::dsp_post6]}) r[xr] = r[xr] + 16'(2 * (xm - 1));
        if (ym inside {[agu_pkg::dsp_post2 : agu_pkg::dsp_post6]}) r[yr] = r[yr] + 16'(2 * (ym - 1));
      end
      dsp_req = {1'b1, xr, agu_pkg::dsp_indirect, yr, agu_pkg::dsp_indirect, 4'hc};
      go;
      chk_req(x_rd_q, ext_f(r[xr], 10'h000, 1));
      chk_req(y_rd_q, ext_f(r[yr], 10'h000, 1));
      dsp_req.valid = 0;
    end
    repeat (3) go;
    chk(32'(n_mem), 32'(n_exp));
    complete_run;
  end
endmodule // tb_top
bind data_space_address_generation agu_monitor mon (.clk, .reset, .page_wr, .move_req, .dsp_req, .read_page_q,
  .write_page_q, .x_rd_q, .x_wr_q, .y_rd_q, .operand_literal_q, .operand_literal_valid_q, .dsp_illegal_q);
